// ---- verilog/serial_program_port.sv ----
// Serial program port with its storage and an AXI4-Lite register slave
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`default_nettype none
module serial_program_port
    import prog_port_pkg::*;
#(
    parameter int unsigned CODE_DEPTH = 1024,
    parameter int unsigned DATA_DEPTH = 64,
    parameter int unsigned INIT_DEPTH = 4,
    parameter logic [9:0]  INIT_BASE  = 10'h040
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  prog_mode,
    input  wire logic                  frame,
    input  wire logic                  sclk,
    input  wire logic                  sdi,
    output logic                       sdo,
    input  wire logic [AXI_ADDR_W-1:0] awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    input  wire logic [AXI_ADDR_W-1:0] araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready
);

    localparam int unsigned CODE_AW = $clog2(CODE_DEPTH);
    localparam int unsigned DATA_AW = $clog2(DATA_DEPTH);
    localparam int unsigned INIT_AW = $clog2(INIT_DEPTH);

    typedef struct packed {
        pins_t                          s1;
        pins_t                          s2;
        logic                           sclk_prev;
        link_state_t                    link;
        logic [5:0]                     bit_cnt;
        logic [1:0]                     tail_cnt;
        logic [15:0]                    timer;
        logic [31:0]                    shift_in;
        cmd_word_t                      cmd;
        logic [31:0]                    resp;
        logic                           sdo;
        logic                           wdone;
        logic                           sw_code;
        logic [9:0]                     sw_addr;
        logic                           aw_got;
        logic [AXI_ADDR_W-1:0]          aw_addr;
        logic                           w_got;
        logic [31:0]                    w_data;
        logic [3:0]                     w_strb;
        logic                           bvalid;
        logic [1:0]                     bresp;
        logic                           rvalid;
        logic [31:0]                    rdata;
        logic [1:0]                     rresp;
        logic [CODE_DEPTH-1:0][7:0]     code;
        logic [DATA_DEPTH-1:0][7:0]     data;
        logic [INIT_DEPTH-1:0][7:0]     init;
    } state_t;

    state_t st_reg;
    state_t st_next;
    pins_t  pins_in;
    logic   c_rise;
    logic   c_fall;

    assign pins_in = '{prog_mode: prog_mode, frame: frame, sclk: sclk, sdi: sdi};
    // Edges come from the second synchroniser stage only
    assign c_rise  = st_reg.s2.sclk & ~st_reg.sclk_prev;
    assign c_fall  = ~st_reg.s2.sclk & st_reg.sclk_prev;

    // Same address decode serves the port and software
    function automatic logic [7:0] mem_read(input state_t s, input logic code_sel,
                                            input logic data_sel, input logic [9:0] a);
        logic [7:0] v;
        logic [9:0] off;
        v   = ERASED_BYTE;
        off = 10'(a - INIT_BASE);
        if (code_sel && ({1'b0, a} < 11'(CODE_DEPTH))) begin
            v = s.code[a[CODE_AW-1:0]];
        end else if (data_sel && ({1'b0, a} < 11'(DATA_DEPTH))) begin
            v = s.data[a[DATA_AW-1:0]];
        end else if (data_sel && (a >= INIT_BASE) && ({1'b0, off} < 11'(INIT_DEPTH))) begin
            v = s.init[off[INIT_AW-1:0]];
        end
        return v;
    endfunction

    function automatic state_t mem_write(input state_t s, input logic code_sel,
                                         input logic data_sel, input logic [9:0] a,
                                         input logic [7:0] d);
        state_t     r;
        logic [9:0] off;
        r   = s;
        off = 10'(a - INIT_BASE);
        if (code_sel && ({1'b0, a} < 11'(CODE_DEPTH))) begin
            r.code[a[CODE_AW-1:0]] = d;
        end else if (data_sel && ({1'b0, a} < 11'(DATA_DEPTH))) begin
            r.data[a[DATA_AW-1:0]] = d;
        end else if (data_sel && (a >= INIT_BASE) && ({1'b0, off} < 11'(INIT_DEPTH))) begin
            r.init[off[INIT_AW-1:0]] = d;
        end
        return r;
    endfunction

    always_comb begin
        st_next = st_reg;
        st_next.s1 = pins_in;
        st_next.s2 = st_reg.s1;
        st_next.sclk_prev = st_reg.s2.sclk;

        // Register bus: address and data may arrive in either order
        if (awvalid && awready) begin
            st_next.aw_got = 1'b1;
            st_next.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            st_next.w_got = 1'b1;
            st_next.w_data = wdata;
            st_next.w_strb = wstrb;
        end
        if (bvalid && bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.aw_got && st_reg.w_got) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = RESP_OKAY;
            if (st_reg.aw_addr == REG_STATUS) begin
                if (st_reg.w_strb[0] && st_reg.w_data[STAT_WDONE]) begin
                    st_next.wdone = 1'b0;
                end
            end else if (st_reg.aw_addr == REG_MEM_ADDR) begin
                if (st_reg.w_strb[0]) begin
                    st_next.sw_addr[7:0] = st_reg.w_data[7:0];
                end
                if (st_reg.w_strb[1]) begin
                    st_next.sw_addr[9:8] = st_reg.w_data[9:8];
                end
                if (st_reg.w_strb[2]) begin
                    st_next.sw_code = st_reg.w_data[MADDR_CODE];
                end
            end else if (st_reg.aw_addr == REG_MEM_DATA) begin
                // Storage belongs to the programmer while the mode is on
                if (st_reg.s2.prog_mode) begin
                    st_next.bresp = RESP_SLVERR;
                end else if (st_reg.w_strb[0]) begin
                    st_next = mem_write(st_next, st_reg.sw_code, ~st_reg.sw_code,
                                        st_reg.sw_addr, st_reg.w_data[7:0]);
                end
            end else if (st_reg.aw_addr == REG_LAST_CMD) begin
                st_next.bresp = RESP_OKAY;
            end else begin
                st_next.bresp = RESP_SLVERR;
            end
        end

        if (rvalid && rready) begin
            st_next.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = RESP_OKAY;
            st_next.rdata = '0;
            if (araddr == REG_STATUS) begin
                st_next.rdata[STAT_WDONE] = st_reg.wdone;
                st_next.rdata[STAT_BUSY] = (st_reg.link == LINK_BUSY);
                st_next.rdata[STAT_PROG] = st_reg.s2.prog_mode;
            end else if (araddr == REG_MEM_ADDR) begin
                st_next.rdata[9:0] = st_reg.sw_addr;
                st_next.rdata[MADDR_CODE] = st_reg.sw_code;
            end else if (araddr == REG_MEM_DATA) begin
                st_next.rdata[7:0] = mem_read(st_reg, st_reg.sw_code, ~st_reg.sw_code,
                                              st_reg.sw_addr);
            end else if (araddr == REG_LAST_CMD) begin
                st_next.rdata = st_reg.cmd;
            end else begin
                st_next.rresp = RESP_SLVERR;
            end
        end

        // Serial link, driven by sampled edges of the programmer's clock
        if (!st_reg.s2.prog_mode) begin
            st_next.link = LINK_OFF;
            st_next.sdo = 1'b1;
        end else begin
            case (st_reg.link)
                LINK_OFF: begin
                    // First word out after entry is filler
                    st_next.link = LINK_SHIFT;
                    st_next.bit_cnt = '0;
                    st_next.resp = '0;
                    st_next.sdo = 1'b0;
                end
                LINK_SHIFT: begin
                    if (!st_reg.s2.frame) begin
                        if (st_reg.bit_cnt == WORD_FULL) begin
                            st_next.link = LINK_TAIL;
                            st_next.cmd = cmd_word_t'(st_reg.shift_in);
                            st_next.tail_cnt = '0;
                            st_next.sdo = 1'b0;
                        end else begin
                            // A short word is dropped rather than executed
                            st_next.bit_cnt = '0;
                        end
                    end else begin
                        if (c_rise && (st_reg.bit_cnt != WORD_FULL)) begin
                            st_next.shift_in = {st_reg.shift_in[30:0],
                                                st_reg.s2.sdi};
                            st_next.bit_cnt = 6'(st_reg.bit_cnt + 6'h01);
                        end
                        if (c_fall) begin
                            st_next.sdo = st_reg.resp[30];
                            st_next.resp = {st_reg.resp[30:0], 1'b0};
                        end
                    end
                end
                LINK_TAIL: begin
                    if (c_rise) begin
                        st_next.tail_cnt = 2'(st_reg.tail_cnt + 2'h1);
                        if (st_reg.tail_cnt == TAIL_LAST) begin
                            if (st_reg.cmd.read) begin
                                st_next.resp = {st_reg.cmd[31:8],
                                                mem_read(st_reg, st_reg.cmd.code_sel,
                                                         st_reg.cmd.data_sel,
                                                         st_reg.cmd.addr)};
                                st_next.link = LINK_DONE;
                                st_next.sdo = 1'b1;
                            end else begin
                                st_next = mem_write(st_next, st_reg.cmd.code_sel,
                                                    st_reg.cmd.data_sel, st_reg.cmd.addr,
                                                    st_reg.cmd.data);
                                st_next.resp = st_reg.cmd;
                                st_next.timer = 16'(WRITE_CYCLES);
                                st_next.link = LINK_BUSY;
                            end
                        end
                    end
                end
                LINK_BUSY: begin
                    st_next.timer = 16'(st_reg.timer - 16'h0001);
                    if (st_reg.timer == 16'h0001) begin
                        st_next.link = LINK_DONE;
                        st_next.sdo = 1'b1;
                    end
                end
                LINK_DONE: begin
                    st_next.sdo = 1'b1;
                    // Next word may only start once the handshake is back high
                    if (st_reg.s2.frame) begin
                        st_next.link = LINK_SHIFT;
                        st_next.bit_cnt = '0;
                        st_next.sdo = st_reg.resp[31];
                    end
                end
                default: begin
                    st_next.link = LINK_OFF;
                end
            endcase
        end

        // Hardware set is placed last so it beats a clear in the same cycle
        if ((st_reg.link == LINK_BUSY) && (st_reg.timer == 16'h0001)
                && st_reg.s2.prog_mode) begin
            st_next.wdone = 1'b1;
        end

        if (!aresetn) begin
            st_next = '0;
            st_next.link = LINK_OFF;
            st_next.sdo = 1'b1;
            st_next.code = {CODE_DEPTH{ERASED_BYTE}};
            st_next.data = {DATA_DEPTH{ERASED_BYTE}};
            st_next.init = {INIT_DEPTH{ERASED_BYTE}};
        end
    end

    always_ff @(posedge aclk) begin
        st_reg <= st_next;
    end

    assign sdo     = st_reg.sdo;
    assign awready = ~st_reg.aw_got & ~st_reg.bvalid;
    assign wready  = ~st_reg.w_got & ~st_reg.bvalid;
    assign bvalid  = st_reg.bvalid;
    assign bresp   = st_reg.bresp;
    assign arready = ~st_reg.rvalid;
    assign rvalid  = st_reg.rvalid;
    assign rdata   = st_reg.rdata;
    assign rresp   = st_reg.rresp;

    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);

    tail_entry_a: assert property ((st_reg.link == LINK_SHIFT)
        && st_reg.s2.prog_mode && !st_reg.s2.frame && (st_reg.bit_cnt == WORD_FULL)
        |=> (st_reg.link == LINK_TAIL) && !sdo ##1 !sdo)
        else $error("serial out not low at start of completion phase");

    write_done_a: assert property ((st_reg.link == LINK_BUSY)
        && (st_reg.timer == 16'h0001) && st_reg.s2.prog_mode
        |=> sdo && st_reg.wdone && (st_reg.link == LINK_DONE))
        else $error("write completion did not raise serial out and status");

    write_time_a: assert property ((st_reg.link == LINK_TAIL) && c_rise
        && (st_reg.tail_cnt == TAIL_LAST) && !st_reg.cmd.read && st_reg.s2.prog_mode
        |=> (st_reg.link == LINK_BUSY) && (st_reg.timer == 16'(WRITE_CYCLES)) && !sdo)
        else $error("write did not start its busy period");

    read_load_a: assert property ((st_reg.link == LINK_TAIL) && c_rise
        && (st_reg.tail_cnt == TAIL_LAST) && st_reg.cmd.read && st_reg.s2.prog_mode
        |=> (st_reg.link == LINK_DONE) && sdo && (st_reg.resp[17:8] == $past(st_reg.cmd.addr)))
        else $error("read response not loaded after second clock");

    shift_in_a: assert property ((st_reg.link == LINK_SHIFT) && st_reg.s2.frame
        && c_rise && (st_reg.bit_cnt != WORD_FULL) && st_reg.s2.prog_mode
        |=> (st_reg.shift_in[0] == $past(st_reg.s2.sdi))
            && (st_reg.bit_cnt == 6'($past(st_reg.bit_cnt) + 6'h01)))
        else $error("command bit not sampled on rising clock");

    shift_out_a: assert property ((st_reg.link == LINK_SHIFT) && st_reg.s2.frame
        && c_fall && st_reg.s2.prog_mode |=> sdo == $past(st_reg.resp[30]))
        else $error("response bit not advanced on falling clock");

    sdo_steady_a: assert property ((st_reg.link == LINK_SHIFT)
        && $past(st_reg.link == LINK_SHIFT) && $past(st_reg.s2.frame) && !$past(c_fall)
        |-> $stable(sdo))
        else $error("serial out moved without a falling clock");

    entry_a: assert property ($rose(st_reg.s2.prog_mode)
        && (st_reg.link == LINK_OFF)
        |=> (st_reg.link == LINK_SHIFT) && (st_reg.bit_cnt == 6'h00))
        else $error("mode entry did not open a fresh word");

    sw_block_a: assert property ($rose(st_reg.bvalid)
        && ($past(st_reg.aw_addr) == REG_MEM_DATA)
        && $past(st_reg.s2.prog_mode) |-> (bresp == RESP_SLVERR))
        else $error("software storage write accepted in programming mode");

endmodule
`default_nettype wire

// ---- verilog/prog_port_pkg.sv ----
// Constants and carrier types for the serial program port
// What this block does
// - In programming mode the programmer reads and writes data, code and init storage.
// - Every exchange is one 32-bit command word in, one response word out.
// - Command words shift in MSB first; bit 31 on the first clock.
// - While a command shifts in, the previous command's response shifts out.
// - The first response after mode entry carries no valid content.
// - With the frame line low, serial out becomes the handshake line.
// - Serial out goes low (busy) by the second rising clock of the low phase.
// - A finished write sets the write-done status bit and returns serial out high.
// - After a read and its two clocks, the byte lands in response bits 7..0.
// - Multi-byte transfers are back-to-back single commands, each with full handshake.
// - Port addresses map to the same storage locations as normal operation.
// - Bit 29 selects data storage or init registers; bit 28 selects code storage.
// - Bit 24 high requests a read, low requests a write.
// - Bits 17..8 carry the byte address; the response echoes them.
// - Bits 7..0 carry write data; the response returns written or read byte.
`default_nettype none
package prog_port_pkg;

    localparam int unsigned CLK_PERIOD_NS = 20;
    // Programming time for one byte
    localparam int unsigned WRITE_TIME_NS = 10000;
    localparam int unsigned WRITE_CYCLES  = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [5:0]  WORD_FULL   = 6'h20;
    localparam logic [1:0]  TAIL_LAST   = 2'h1;
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;

    localparam int unsigned AXI_ADDR_W   = 12;
    localparam logic [11:0] REG_STATUS   = 12'h000;
    localparam logic [11:0] REG_MEM_ADDR = 12'h004;
    localparam logic [11:0] REG_MEM_DATA = 12'h008;
    localparam logic [11:0] REG_LAST_CMD = 12'h00C;

    localparam int unsigned STAT_WDONE = 0;
    localparam int unsigned STAT_BUSY  = 1;
    localparam int unsigned STAT_PROG  = 2;
    localparam int unsigned MADDR_CODE = 16;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] zero_hi;
        logic       data_sel;
        logic       code_sel;
        logic [2:0] zero_mid;
        logic       read;
        logic [5:0] zero_lo;
        logic [9:0] addr;
        logic [7:0] data;
    } cmd_word_t;

    typedef struct packed {
        logic prog_mode;
        logic frame;
        logic sclk;
        logic sdi;
    } pins_t;

    typedef enum logic [2:0] {
        LINK_OFF   = 3'b000,
        LINK_SHIFT = 3'b001,
        LINK_TAIL  = 3'b010,
        LINK_BUSY  = 3'b011,
        LINK_DONE  = 3'b100
    } link_state_t;

endpackage
`default_nettype wire

// ---- verification/prog_model.sv ----
// Behavioural external programmer driving the four-wire link
`default_nettype none
module prog_model
    import prog_port_pkg::*;
(
    input  wire logic aclk,
    input  wire logic sdo,
    output var  pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;

    logic busy_low = 1'h0;

    initial pins = '0;

    task automatic ticks(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // One link clock is 8 aclk; sdo is taken mid-high, clear of the device's fall update
    task automatic pulse(input logic b, output logic seen);
        pins.sdi <= b;
        ticks(4);
        pins.sclk <= 1'h1;
        ticks(2);
        seen = sdo;
        ticks(2);
        pins.sclk <= 1'h0;
    endtask

    task automatic set_mode(input logic on);
        pins.prog_mode <= on;
        pins.frame <= 1'h0;
        ticks(8);
    endtask

    // Link clock stands low between frames; sdi toggles once its bits are spent
    task automatic xfer(input logic [31:0] cmd, output logic [31:0] resp);
        logic seen;
        pins.frame <= 1'h1;
        ticks(4);
        for (int i = 31; i >= 0; i--) begin
            pulse(cmd[i], resp[i]);
        end
        pins.frame <= 1'h0;
        ticks(4);
        pulse(~pins.sdi, seen);
        pulse(~pins.sdi, seen);
        busy_low = (seen === 1'h0);
        while (sdo !== 1'h1) ticks(1);
    endtask
endmodule
`default_nettype wire

// ---- verification/serial_program_port_tb.sv ----
// Self-checking bench: register bus accesses plus programmer-driven link cycles
`default_nettype none
module serial_program_port_tb
    import prog_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  aclk;
    logic                  aresetn = 1'h0;
    logic                  sdo;
    pins_t                 pins;
    logic [AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0]           wdata = '0, rdata;
    logic [3:0]            wstrb = 4'hF;
    logic                  awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
    logic                  bready = 1'h1, rready = 1'h1;
    logic                  awready, wready, bvalid, arready, rvalid;
    logic [1:0]            bresp, rresp;
    logic [31:0]           cmds [8];
    logic [17:0]           exps [8];
    int                    n_fail = 0;
    int                    checks = 0;

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

    serial_program_port uut (
        .aclk(aclk), .aresetn(aresetn), .prog_mode(pins.prog_mode), .frame(pins.frame),
        .sclk(pins.sclk), .sdi(pins.sdi), .sdo(sdo), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );
    prog_model prog (.aclk(aclk), .sdo(sdo), .pins(pins));

    initial begin
        aclk = 1'h0;
        forever #10 aclk = ~aclk;
    end

    function automatic logic [31:0] mk(input logic [1:0] sel, input logic rd,
                                       input logic [9:0] a, input logic [7:0] d);
        cmd_word_t c;
        c = '0;
        {c.data_sel, c.code_sel} = sel;
        c.read = rd;
        c.addr = a;
        c.data = d;
        return c;
    endfunction

    // Ready lines are read before this edge's updates land, so each is the sampled value
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            aw_ok = aw_ok || (awready === 1'h1);
            w_ok = w_ok || (wready === 1'h1);
            awvalid <= !aw_ok;
            wvalid <= !w_ok;
        end
        do @(posedge aclk); while (bvalid !== 1'h1);
        r = bresp;
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge aclk); while (rvalid !== 1'h1);
        d = rdata;
        r = rresp;
    endtask

    task automatic end_test(input string nm);
        $display("test %s finished, %0d checks so far", nm, checks);
    endtask

    task automatic summarize();
        $display("checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // About 10 link cycles of under 900 aclk each; the limit leaves ample margin
    initial begin
        repeat (50000) @(posedge aclk);
        n_fail++;
        $display("watchdog expired");
        summarize();
    end

    initial begin
        logic [31:0] rsp, rd;
        logic [1:0]  r;
        cmds = '{mk(2'h2, 1'h0, 10'h005, 8'hA5), mk(2'h1, 1'h0, 10'h3FF, 8'h3C),
                 mk(2'h2, 1'h0, 10'h041, 8'h5A), mk(2'h2, 1'h1, 10'h005, 8'h00),
                 mk(2'h1, 1'h1, 10'h3FF, 8'h00), mk(2'h2, 1'h1, 10'h010, 8'h00),
                 mk(2'h2, 1'h1, 10'h041, 8'h00), mk(2'h2, 1'h1, 10'h020, 8'h00)};
        exps = '{18'h0, {10'h005, 8'hA5}, {10'h3FF, 8'h3C}, {10'h041, 8'h5A},
                 {10'h005, 8'hA5}, {10'h3FF, 8'h3C}, {10'h010, 8'hFF}, {10'h041, 8'h5A}};
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        axi_rd(REG_STATUS, rd, r);
        `CHK("status at reset", 3'h0, rd[2:0])
        axi_rd(12'h010, rd, r);
        `CHK("unmapped read", RESP_SLVERR, r)
        end_test("reset");
        prog.set_mode(1'h1);
        // First response after entry is undefined, so it is not compared
        for (int i = 0; i < 8; i++) begin
            prog.xfer(cmds[i], rsp);
            `CHK("busy by second rise", 1'h1, prog.busy_low)
            if (i > 0) begin
                `CHK("echoed address", exps[i][17:8], rsp[17:8])
                `CHK("response byte", exps[i][7:0], rsp[7:0])
            end
        end
        end_test("link cycles");
        axi_rd(REG_LAST_CMD, rd, r);
        `CHK("last command", cmds[7], rd)
        axi_rd(REG_STATUS, rd, r);
        `CHK("status after writes", 3'h5, rd[2:0])
        axi_wr(REG_STATUS, 32'h0000_0001, r);
        axi_rd(REG_STATUS, rd, r);
        `CHK("done cleared", 3'h4, rd[2:0])
        axi_wr(REG_MEM_DATA, 32'h0000_0011, r);
        `CHK("bus write in mode", RESP_SLVERR, r)
        end_test("status");
        prog.set_mode(1'h0);
        axi_wr(REG_MEM_ADDR, 32'h0001_03FF, r);
        axi_rd(REG_MEM_DATA, rd, r);
        `CHK("code byte by bus", 8'h3C, rd[7:0])
        axi_wr(REG_MEM_ADDR, 32'h0000_0020, r);
        axi_wr(REG_MEM_DATA, 32'h0000_0077, r);
        `CHK("bus write", RESP_OKAY, r)
        prog.set_mode(1'h1);
        prog.xfer(mk(2'h2, 1'h1, 10'h020, 8'h00), rsp);
        prog.xfer(mk(2'h2, 1'h1, 10'h000, 8'h00), rsp);
        `CHK("bus byte by link", {10'h020, 8'h77}, rsp[17:0])
        end_test("mapping");
        summarize();
    end
endmodule
`default_nettype wire
